// ---- verilog/fspc_top.sv ----
// Purpose: self-programming sequencer for on-chip program flash
// Assumes: store/load instruction strobes arrive as one-cycle pulses from the core
// Notes: Avalon-MM slave with one wait cycle on every access
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
module fspc_top
    import fspc_pkg::*;
#(
    parameter int WORD_BITS = 6,                       // word index width
    parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 16'h01C0, // first page of non-shared section
    parameter logic [15:0] BOOT_RESET_ADDR = 16'h7000,
    parameter logic [7:0] SIG_DEFAULT = 8'h5A          // arbitrary signature value
) (
    input wire logic sys_clk,            // 125 MHz clock
    input wire logic rst_b,              // sync reset, low active
    input wire logic ce,                 // clock enable
    input wire logic [3:0] avs_address,  // byte address
    input wire logic avs_read,           // read request
    input wire logic avs_write,          // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata,    // read data
    output logic avs_waitrequest,        // wait
    input wire logic store_req,          // store instruction pulse
    input wire logic load_req,           // load instruction pulse
    input wire logic global_irq_en,      // core global interrupt flag
    input wire logic eeprom_busy,        // EEPROM write running
    input wire logic boot_reset_fuse,    // 0 = programmed
    input wire fspc_nv_t nv_bits,        // fuse and lock bytes
    input wire logic fl_done,            // flash op finished pulse
    input wire logic [WORD_BITS-1:0] fl_buf_idx, // buffer read index
    output logic [15:0] fl_buf_data,     // buffer word at index
    output fspc_req_t fl_req,            // flash op request
    output logic fl_start,               // op start pulse
    output logic lock_wr,                // lock program pulse
    output logic [7:0] lock_data,        // lock byte to program
    output logic [7:0] load_data,        // special load result
    output logic load_hit,               // load served here
    output logic cpu_halt,               // stall core
    output logic rww_block,              // shared section unreadable
    output logic ready_irq,              // ready interrupt request
    output logic [15:0] reset_vector     // selected reset address
);
    localparam int PAGES = 1 << WORD_BITS;
    localparam int PW = 15 - WORD_BITS;

    logic [7:0] ctrl_reg;
    logic [15:0] ptr_reg;
    logic [15:0] data_reg;
    logic [2:0] win_reg;
    fspc_state_t state_reg;
    logic [15:0] buf_mem [PAGES];
    logic [PAGES-1:0] buf_vld_reg;
    logic [PW-1:0] page_reg;
    logic boot_seen_reg;
    logic wr_ok;
    logic rd_ok;
    logic ctrl_wr;
    logic cmd_ok;
    logic store_ok;
    logic load_ok;
    logic buf_clr;
    logic buf_ld;
    logic [WORD_BITS-1:0] widx;
    logic [PW-1:0] pptr;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    assign wr_ok = ce && avs_write && !avs_waitrequest;
    assign rd_ok = ce && avs_read && !avs_waitrequest;
    assign ctrl_wr = wr_ok && avs_address == OFF_CTRL;
    assign cmd_ok = avs_writedata[4:0] inside {CMD_REEN, CMD_LOCK, CMD_PGWR, CMD_PGER, CMD_LOAD};
    assign widx = ptr_reg[WORD_BITS:1];
    assign pptr = ptr_reg[15:WORD_BITS+1];
    assign store_ok = ce && store_req && state_reg == FSPC_ARMED && win_reg != 3'h0;
    assign load_ok = ce && load_req && state_reg == FSPC_ARMED && win_reg > (STORE_WIN - LOAD_WIN);
    assign buf_ld = store_ok && !eeprom_busy && ctrl_reg[5:0] == {1'b0, CMD_LOAD};

    // one wait cycle, then a one-cycle answer
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ce && (avs_read && avs_waitrequest)) begin
            unique case (avs_address)
                OFF_CTRL: avs_readdata <= {24'h000000, ctrl_reg[7], rww_block, ctrl_reg[5:0]};
                OFF_PTR: avs_readdata <= {16'h0000, ptr_reg};
                OFF_DATA: avs_readdata <= {16'h0000, data_reg};
                OFF_STAT: avs_readdata <= {28'h0000000, cpu_halt, rww_block,
                    state_reg};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ptr_reg <= 16'h0000;
            data_reg <= 16'h0000;
        end else if (wr_ok) begin
            if (avs_address == OFF_PTR) begin
                ptr_reg <= avs_writedata[15:0];
            end
            if (avs_address == OFF_DATA) begin
                data_reg <= avs_writedata[15:0];
            end
        end
    end

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_reg <= FSPC_IDLE;
            ctrl_reg <= CTRL_RESET;
            win_reg <= 3'h0;
            page_reg <= '0;
            fl_start <= 1'b0;
            fl_req <= '0;
            lock_wr <= 1'b0;
            lock_data <= 8'hFF;
            cpu_halt <= 1'b0;
        end else if (ce) begin
            fl_start <= 1'b0;
            lock_wr <= 1'b0;
            if (ctrl_wr) begin
                ctrl_reg[B_IRQ_EN] <= avs_writedata[B_IRQ_EN];
            end
            unique case (state_reg)
                FSPC_IDLE: begin
                    if (ctrl_wr && cmd_ok && !eeprom_busy) begin
                        ctrl_reg[4:0] <= avs_writedata[4:0];
                        // signature read rides only on the plain enable code
                        ctrl_reg[B_SIG] <= avs_writedata[B_SIG] && avs_writedata[4:0] == CMD_LOAD;
                        win_reg <= STORE_WIN;
                        state_reg <= FSPC_ARMED;
                    end
                end
                FSPC_ARMED: begin
                    win_reg <= win_reg - 3'h1;
                    if (store_ok && !eeprom_busy) begin
                        if (ctrl_reg[B_PGER] || ctrl_reg[B_PGWR]) begin
                            page_reg <= pptr;
                            fl_req.op <= ctrl_reg[B_PGER] ? FSPC_OP_ERASE : FSPC_OP_WRITE;
                            fl_req.page <= {{(16-PW){1'b0}}, pptr};
                            fl_start <= 1'b1;
                            cpu_halt <= {{(16-PW){1'b0}}, pptr} >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
                            state_reg <= FSPC_BUSY;
                        end else begin
                            if (ctrl_reg[B_LOCK]) begin
                                lock_wr <= 1'b1;
                                lock_data <= data_reg[7:0];
                            end
                            ctrl_reg[5:0] <= 6'h00;
                            state_reg <= FSPC_IDLE;
                        end
                    end else if (load_ok || win_reg == 3'h1) begin
                        ctrl_reg[5:0] <= 6'h00;
                        state_reg <= FSPC_IDLE;
                    end
                end
                FSPC_BUSY: begin
                    if (fl_done) begin
                        ctrl_reg[5:0] <= 6'h00;
                        cpu_halt <= 1'b0;
                        fl_req.op <= FSPC_OP_NONE;
                        state_reg <= FSPC_IDLE;
                    end
                end
                default: state_reg <= FSPC_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rww_block <= 1'b0;
        end else if (ce) begin
            if (store_ok && !eeprom_busy && (ctrl_reg[B_PGER] || ctrl_reg[B_PGWR])
                    && {{(16-PW){1'b0}}, pptr} < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) begin
                rww_block <= 1'b1;
            end else if ((store_ok && !eeprom_busy && ctrl_reg[B_REEN]) || buf_ld) begin
                rww_block <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // temporary page buffer
    // ----------------------------------------
    // buffer clear events
    assign buf_clr = (ctrl_wr && cmd_ok && state_reg == FSPC_IDLE && !eeprom_busy
            && avs_writedata[4:0] == CMD_REEN)
        || (state_reg == FSPC_BUSY && fl_done && fl_req.op == FSPC_OP_WRITE);

    // valid bits model the erased buffer without a wide clear of the array
    genvar gi;
    generate
        for (gi = 0; gi < PAGES; gi++) begin : g_vld
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    buf_vld_reg[gi] <= 1'b0;
                end else if (ce) begin
                    if (buf_clr) begin
                        buf_vld_reg[gi] <= 1'b0;
                    end else if (buf_ld && widx == gi) begin
                        buf_vld_reg[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (buf_ld) begin
            buf_mem[widx] <= data_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fl_buf_data <= ERASED_WORD;
        end else if (ce) begin
            fl_buf_data <= buf_vld_reg[fl_buf_idx] ? buf_mem[fl_buf_idx] : ERASED_WORD;
        end
    end

    // ----------------------------------------
    // special loads
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            load_data <= 8'h00;
            load_hit <= 1'b0;
        end else if (ce) begin
            load_hit <= 1'b0;
            if (load_ok && ctrl_reg[B_SIG]) begin
                load_data <= SIG_DEFAULT;
                load_hit <= 1'b1;
            end else if (load_ok && ctrl_reg[B_LOCK] && !eeprom_busy) begin
                unique case (ptr_reg[1:0])
                    2'b00: load_data <= nv_bits.fuse_low;
                    2'b01: load_data <= nv_bits.lock;
                    2'b10: load_data <= nv_bits.fuse_ext;
                    2'b11: load_data <= nv_bits.fuse_high;
                endcase
                load_hit <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // interrupt and reset vector
    // ----------------------------------------
    // level request while idle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ready_irq <= 1'b0;
        end else if (ce) begin
            ready_irq <= ctrl_reg[B_IRQ_EN] && global_irq_en && !ctrl_reg[B_EN];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reset_vector <= APP_RESET_ADDR;
            boot_seen_reg <= 1'b0;
        end else if (ce && !boot_seen_reg) begin
            reset_vector <= boot_reset_fuse ? APP_RESET_ADDR : BOOT_RESET_ADDR;
            boot_seen_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_win_timeout: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (ce && ctrl_wr && cmd_ok && state_reg == FSPC_IDLE && !eeprom_busy)
        ##1 (ce && !store_req && !load_req)[*4] |=> ctrl_reg[4:0] == 5'h00)
        else $error("command not cleared after window");
    a_bad_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (ce && ctrl_wr && !cmd_ok && state_reg == FSPC_IDLE) |=> $stable(ctrl_reg[4:0]))
        else $error("illegal code changed command");
    a_halt_no_read_while_write_section: assert property (@(posedge sys_clk) disable iff (!rst_b)
        fl_start && fl_req.page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> cpu_halt)
        else $error("core not halted for non-shared page");
    a_busy_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        fl_start && fl_req.page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> rww_block && !cpu_halt)
        else $error("busy flag missing on shared page op");
    a_en_held: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_reg == FSPC_BUSY && !fl_done |=> ctrl_reg[B_EN])
        else $error("enable dropped during op");
    a_page_latch: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_reg == FSPC_BUSY |-> fl_req.page == {{(16-PW){1'b0}}, page_reg})
        else $error("latched page changed");
    a_lock_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lock_wr |-> lock_data == $past(data_reg[7:0]) && ctrl_reg[B_LOCK] == 1'b0)
        else $error("lock byte wrong");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && $past(ce) && ctrl_reg[B_EN] ##1 ce |-> !ready_irq)
        else $error("irq while enable set");
    a_buf_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && buf_clr |=> buf_vld_reg == '0)
        else $error("buffer not cleared");
    a_reen_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_reg == FSPC_BUSY && ctrl_wr && !fl_done |=> ctrl_reg[4:0] == $past(ctrl_reg[4:0]))
        else $error("command accepted while busy");
    a_busy_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        buf_ld |=> !rww_block)
        else $error("busy flag kept after buffer load");
    a_buf_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
        buf_ld |=> buf_mem[$past(widx)] == $past(data_reg))
        else $error("buffer word not stored");
    a_sig_store: assert property (@(posedge sys_clk) disable iff (!rst_b)
        store_ok && ctrl_reg[B_SIG] |=> !fl_start && !lock_wr && $stable(buf_vld_reg))
        else $error("store acted under signature command");
    a_eeprom_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ctrl_wr && eeprom_busy && state_reg == FSPC_IDLE |=> state_reg == FSPC_IDLE)
        else $error("command taken during EEPROM write");
endmodule : fspc_top

// ---- verilog/fspc_pkg.sv ----
// Purpose: shared constants and types of the flash self-programming controller
// Assumes: 8-bit control register, 16-bit pointer, Avalon-MM word registers
// Notes: offsets are byte addresses
package fspc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_PTR = 4'h4;
    localparam logic [3:0] OFF_DATA = 4'h8;
    localparam logic [3:0] OFF_STAT = 4'hC;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int B_IRQ_EN = 7;
    localparam int B_RWW_BUSY = 6;
    localparam int B_SIG = 5;
    localparam int B_REEN = 4;
    localparam int B_LOCK = 3;
    localparam int B_PGWR = 2;
    localparam int B_PGER = 1;
    localparam int B_EN = 0;
    localparam logic [4:0] CMD_REEN = 5'h11;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_PGWR = 5'h05;
    localparam logic [4:0] CMD_PGER = 5'h03;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    // ----------------------------------------
    // timing in clock cycles, reset address and erased word
    // ----------------------------------------
    localparam logic [2:0] STORE_WIN = 3'h4;
    localparam logic [2:0] LOAD_WIN = 3'h3;
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        FSPC_IDLE = 2'b00,
        FSPC_ARMED = 2'b01,
        FSPC_BUSY = 2'b10
    } fspc_state_t;
    typedef enum logic [1:0] {
        FSPC_OP_NONE = 2'b00,
        FSPC_OP_ERASE = 2'b01,
        FSPC_OP_WRITE = 2'b10
    } fspc_op_t;
    typedef struct packed {
        fspc_op_t op;
        logic [15:0] page;
    } fspc_req_t;
    typedef struct packed {
        logic [7:0] fuse_low;
        logic [7:0] fuse_high;
        logic [7:0] fuse_ext;
        logic [7:0] lock;
    } fspc_nv_t;
endpackage : fspc_pkg

// ---- test/fspc_core_model.sv ----
// Purpose: far side of the sequencer: core instruction strobes and flash array
// Assumes: the array reports completion a fixed number of cycles after a start
// Notes: issue() is called at a rising edge by the bench
`timescale 1ns/1ns
module fspc_core_model
    import fspc_pkg::*;
#(
    parameter int DONE_DLY = 40
) (
    input wire logic sys_clk,  // core clock
    input wire logic rst_b,    // sync reset, low active
    input wire logic fl_start, // flash op start pulse
    output logic store_req,    // store instruction pulse
    output logic load_req,     // load instruction pulse
    output logic fl_done       // flash op finished pulse
);
    int cnt;
    initial begin
        store_req = 1'h0;
        load_req = 1'h0;
        fl_done = 1'h0;
        cnt = 0;
    end
    // ----------------------------------------
    // flash array
    // ----------------------------------------
    // a slow array keeps the op open long enough for bus traffic meanwhile
    always @(posedge sys_clk) begin
        fl_done <= 1'h0;
        if (!rst_b) begin
            cnt <= 0;
        end else if (fl_start) begin
            cnt <= DONE_DLY;
        end else if (cnt == 1) begin
            cnt <= 0;
            fl_done <= 1'h1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
    // ----------------------------------------
    // instruction strobes
    // ----------------------------------------
    // store or load placed d edges after arming
    task issue(input bit is_load, input int d);
        repeat (d) @(posedge sys_clk);
        if (is_load) begin
            load_req <= 1'h1;
        end else begin
            store_req <= 1'h1;
        end
        @(posedge sys_clk);
        load_req <= 1'h0;
        store_req <= 1'h0;
    endtask : issue
endmodule : fspc_core_model

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the flash self-programming sequencer
// Assumes: core model answers each flash start after a fixed delay
// Notes: reset checks first, then command table, then hand-written cases
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
    import fspc_pkg::*;
;
    typedef struct packed {
        logic [7:0] code;
        logic [2:0] dly;
        logic start;
        logic lockw;
        logic busy;
        fspc_op_t op;
    } fspc_row_t;
    logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, store_req, load_req;
    logic global_irq_en, eeprom_busy, boot_reset_fuse, fl_done, fl_start, lock_wr;
    logic load_hit, cpu_halt, rww_block, ready_irq;
    logic ce = 1'h1;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [5:0] fl_buf_idx;
    logic [15:0] fl_buf_data, reset_vector;
    logic [7:0] lock_data, load_data;
    fspc_req_t fl_req;
    fspc_nv_t nv_bits = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic [7:0] fz [4] = '{8'h11, 8'h44, 8'h33, 8'h22};
    int miscompares = 0, n_tests = 0, cycles = 0;
    fspc_row_t rows [8] = '{
        '{8'h03, 3'h0, 1'h1, 1'h0, 1'h1, FSPC_OP_ERASE},
        '{8'h05, 3'h3, 1'h1, 1'h0, 1'h1, FSPC_OP_WRITE},
        '{8'h09, 3'h0, 1'h0, 1'h1, 1'h1, FSPC_OP_NONE},
        '{8'h11, 3'h1, 1'h0, 1'h0, 1'h0, FSPC_OP_NONE},
        '{8'h03, 3'h4, 1'h0, 1'h0, 1'h0, FSPC_OP_NONE},
        '{8'h07, 3'h0, 1'h0, 1'h0, 1'h0, FSPC_OP_NONE},
        '{8'h0D, 3'h0, 1'h0, 1'h0, 1'h0, FSPC_OP_NONE},
        '{8'h02, 3'h0, 1'h0, 1'h0, 1'h0, FSPC_OP_NONE}};
    fspc_top #(.SIG_DEFAULT(8'h3C)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .store_req(store_req), .load_req(load_req),
        .global_irq_en(global_irq_en), .eeprom_busy(eeprom_busy),
        .boot_reset_fuse(boot_reset_fuse), .nv_bits(nv_bits), .fl_done(fl_done),
        .fl_buf_idx(fl_buf_idx), .fl_buf_data(fl_buf_data), .fl_req(fl_req),
        .fl_start(fl_start), .lock_wr(lock_wr), .lock_data(lock_data),
        .load_data(load_data), .load_hit(load_hit), .cpu_halt(cpu_halt),
        .rww_block(rww_block), .ready_irq(ready_irq), .reset_vector(reset_vector));
    fspc_core_model #(.DONE_DLY(40)) core_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .fl_start(fl_start), .store_req(store_req), .load_req(load_req), .fl_done(fl_done));
    // ----------------------------------------
    // clock, watchdog, closing
    // ----------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end
    task end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // bus and helpers
    // ----------------------------------------
    task bus_acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask : bus_acc
    task wait_idle();
        while (fl_req.op !== FSPC_OP_NONE) begin
            @(posedge sys_clk);
        end
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : wait_idle
    task buf_at(input logic [5:0] i);
        @(posedge sys_clk);
        fl_buf_idx <= i;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : buf_at
    task do_reset();
        @(posedge sys_clk);
        rst_b <= 1'h0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : do_reset
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {avs_read, avs_write, global_irq_en, eeprom_busy} = 4'h0;
        {avs_address, avs_writedata, fl_buf_idx} = '0;
        boot_reset_fuse = 1'h1;
        rst_b = 1'h0;
        do_reset();
        `CHK(reset_vector, APP_RESET_ADDR)
        `CHK(fl_buf_data, ERASED_WORD)
        bus_acc(0, OFF_CTRL, 0);
        `CHK(q[7:0], CTRL_RESET)
        bus_acc(0, 4'h2, 0);
        `CHK(q, 32'h0)
        $display("reset test done");
        bus_acc(1, OFF_PTR, 32'h0280);
        bus_acc(1, OFF_DATA, 32'h00A5);
        foreach (rows[i]) begin
            bus_acc(1, OFF_CTRL, {24'h0, rows[i].code});
            core_u.issue(0, rows[i].dly);
            #1;
            `CHK(fl_start, rows[i].start)
            `CHK(lock_wr, rows[i].lockw)
            `CHK(fl_req.op, rows[i].op)
            if (rows[i].start) `CHK(fl_req.page, 16'h0005)
            if (rows[i].lockw) `CHK(lock_data, 8'hA5)
            wait_idle();
            `CHK(rww_block, rows[i].busy)
            bus_acc(0, OFF_CTRL, 0);
            `CHK(q[B_EN], 1'h0)
        end
        $display("command table done");
        bus_acc(1, OFF_CTRL, 32'h03);
        core_u.issue(0, 0);
        bus_acc(1, OFF_CTRL, 32'h11);
        core_u.issue(0, 0);
        bus_acc(1, OFF_PTR, 32'h000B);
        bus_acc(1, OFF_DATA, 32'h1234);
        `CHK(fl_req.page, 16'h0005)
        bus_acc(0, OFF_CTRL, 0);
        `CHK(q[B_EN], 1'h1)
        `CHK(q[B_RWW_BUSY], 1'h1)
        wait_idle();
        `CHK(rww_block, 1'h1)
        bus_acc(1, OFF_CTRL, 32'h01);
        core_u.issue(0, 2);
        buf_at(6'h05);
        `CHK(rww_block, 1'h0)
        `CHK(fl_buf_data, 16'h1234)
        buf_at(6'h00);
        `CHK(fl_buf_data, ERASED_WORD)
        bus_acc(1, OFF_CTRL, 32'h11);
        core_u.issue(0, 0);
        buf_at(6'h05);
        `CHK(fl_buf_data, ERASED_WORD)
        $display("buffer test done");
        bus_acc(1, OFF_PTR, 32'hE000);
        bus_acc(1, OFF_CTRL, 32'h03);
        core_u.issue(0, 0);
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(cpu_halt, 1'h1)
        `CHK(rww_block, 1'h0)
        wait_idle();
        `CHK(cpu_halt, 1'h0)
        $display("halt test done");
        for (int i = 0; i < 5; i++) begin
            bus_acc(1, OFF_PTR, i);
            bus_acc(1, OFF_CTRL, (i == 4) ? 32'h21 : 32'h09);
            core_u.issue(1, i % 3);
            #1;
            `CHK(load_hit, 1'h1)
            `CHK(load_data, (i == 4) ? 8'h3C : fz[i % 4])
        end
        bus_acc(1, OFF_CTRL, 32'h21);
        core_u.issue(0, 0);
        #1;
        `CHK(fl_start, 1'h0)
        buf_at(6'h02);
        `CHK(fl_buf_data, ERASED_WORD)
        $display("load test done");
        @(posedge sys_clk);
        eeprom_busy <= 1'h1;
        bus_acc(1, OFF_CTRL, 32'h03);
        core_u.issue(0, 0);
        #1;
        `CHK(fl_start, 1'h0)
        bus_acc(1, OFF_CTRL, 32'h09);
        core_u.issue(1, 0);
        #1;
        `CHK(load_hit, 1'h0)
        @(posedge sys_clk);
        eeprom_busy <= 1'h0;
        global_irq_en <= 1'h1;
        repeat (6) @(posedge sys_clk);
        bus_acc(1, OFF_CTRL, 32'h80);
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(ready_irq, 1'h1)
        bus_acc(1, OFF_CTRL, 32'h81);
        @(posedge sys_clk);
        #1;
        `CHK(ready_irq, 1'h0)
        @(posedge sys_clk);
        global_irq_en <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(ready_irq, 1'h0)
        @(posedge sys_clk);
        boot_reset_fuse <= 1'h0;
        do_reset();
        `CHK(reset_vector, 16'h7000)
        $display("fuse and irq test done");
        end_sim();
    end
endmodule : tb_top
